/* hw/lsx_exec.sv */
// Load and store execution unit of the 8-bit core.
`timescale 1ns/1ps
`default_nettype none
`include "lsx_consts.svh"
module lsx_exec (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire lsx_pkg::lsx_cmd_s cmd,
    input wire logic ptr_load,
    input wire lsx_pkg::lsx_ptr_e ptr_load_sel,
    input wire logic [15:0] ptr_load_value,
    input wire logic page_load,
    input wire logic [7:0] page_value,
    input wire logic [7:0] data_rdata,
    input wire logic [7:0] prog_rdata,
    output logic busy,
    output lsx_pkg::lsx_wb_s wb,
    output logic data_re,
    output logic data_we,
    output logic [15:0] data_addr,
    output logic [7:0] data_wdata,
    output logic prog_re,
    output logic [23:0] prog_addr,
    output logic [15:0] ptr_a,
    output logic [15:0] ptr_b,
    output logic [15:0] ptr_c,
    output logic [7:0] program_page_extension
);
    import lsx_pkg::*;

    // ------------------------------------------------------------
    // Pointer pairs
    // ------------------------------------------------------------
    logic [2:0] p_load;
    logic [2:0] p_up;
    logic [2:0] p_down;
    logic [15:0] p_val [3];
    logic [15:0] p_dec [3];
    logic ext_step;
    logic ext_carry;

    // Three identical pointer pairs.
    for (genvar i = 0; i < 3; i++) begin : g_ptr
        lsx_pointer u_ptr (
            .clk(clk),
            .rst(rst),
            .load(p_load[i]),
            .load_value(ptr_load_value),
            .step_up(p_up[i]),
            .step_down(p_down[i]),
            .value(p_val[i]),
            .value_dec(p_dec[i])
        );
    end

    // Page extension above ptr_c.
    lsx_ext_pointer u_ext (
        .clk(clk),
        .rst(rst),
        .page_load(page_load),
        .page_value(page_value),
        .ext_step(ext_step),
        .ptr_c(p_val[2]),
        .program_page_extension(program_page_extension),
        .ext_carry(ext_carry)
    );

    // Pointer outputs come straight from the pointer flip-flops.
    assign ptr_a = p_val[0];
    assign ptr_b = p_val[1];
    assign ptr_c = p_val[2];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    lsx_state_e state;
    lsx_state_e next_state;
    lsx_cmd_s held;
    lsx_cmd_s next_held;
    logic next_busy;
    lsx_wb_s next_wb;
    logic next_data_re;
    logic next_data_we;
    logic [15:0] next_data_addr;
    logic [7:0] next_data_wdata;
    logic next_prog_re;
    logic [23:0] next_prog_addr;
    logic [1:0] sel;
    logic [15:0] ptr_now;
    logic [15:0] ptr_pre;
    logic is_write;
    logic is_prog;

    // Decode of the accepted command.
    always_comb begin
        sel = cmd.ptr;
        if (sel == 2'h3) begin
            sel = 2'h2;
        end
        ptr_now = p_val[sel];
        ptr_pre = p_dec[sel];
        is_write = (cmd.op == LSX_OP_DIRECT_WRITE)
            || (cmd.op == LSX_OP_WRITE_PLAIN)
            || (cmd.op == LSX_OP_WRITE_POSTINC)
            || (cmd.op == LSX_OP_WRITE_PREDEC)
            || (cmd.op == LSX_OP_OFFSET_WRITE);
        is_prog = (cmd.op == LSX_OP_PROG_READ)
            || (cmd.op == LSX_OP_PROG_READ_INC)
            || (cmd.op == LSX_OP_EXT_READ)
            || (cmd.op == LSX_OP_EXT_READ_INC);
    end

    // Next state, memory strobes, pointer steps and write-back.
    always_comb begin
        next_state = state;
        next_held = held;
        next_busy = busy;
        next_wb = '0;
        next_data_re = 1'b0;
        next_data_we = 1'b0;
        next_data_addr = data_addr;
        next_data_wdata = data_wdata;
        next_prog_re = 1'b0;
        next_prog_addr = prog_addr;
        p_load = 3'b000;
        p_up = 3'b000;
        p_down = 3'b000;
        ext_step = 1'b0;
        if (ptr_load) begin
            p_load[ptr_load_sel] = 1'b1;
        end
        case (state)
            LSX_ST_IDLE: begin
                if (cmd_valid) begin
                    next_held = cmd;
                    next_busy = 1'b1;
                    next_state = LSX_ST_ACCESS;
                    next_data_wdata = cmd.source_register;
                    case (cmd.op)
                        LSX_OP_DIRECT_READ: begin
                            next_data_re = 1'b1;
                            next_data_addr = cmd.address;
                        end
                        LSX_OP_DIRECT_WRITE: begin
                            next_data_we = 1'b1;
                            next_data_addr = cmd.address;
                        end
                        LSX_OP_WRITE_PLAIN: begin
                            next_data_we = 1'b1;
                            next_data_addr = ptr_now;
                        end
                        LSX_OP_WRITE_POSTINC: begin
                            // Store at the old value, then step up.
                            next_data_we = 1'b1;
                            next_data_addr = ptr_now;
                            p_up[sel] = 1'b1;
                        end
                        LSX_OP_WRITE_PREDEC: begin
                            // Step down, store at the new value.
                            next_data_we = 1'b1;
                            next_data_addr = ptr_pre;
                            p_down[sel] = 1'b1;
                        end
                        LSX_OP_OFFSET_WRITE: begin
                            next_data_we = 1'b1;
                            next_data_addr = p_val[2]
                                + {10'h000, cmd.displacement};
                        end
                        LSX_OP_PROG_READ, LSX_OP_PROG_READ_INC: begin
                            next_prog_re = 1'b1;
                            next_prog_addr = {8'h00, p_val[2]};
                            p_up[2] = (cmd.op == LSX_OP_PROG_READ_INC);
                        end
                        LSX_OP_EXT_READ, LSX_OP_EXT_READ_INC: begin
                            next_prog_re = 1'b1;
                            next_prog_addr = {program_page_extension,
                                p_val[2]};
                            p_up[2] = (cmd.op == LSX_OP_EXT_READ_INC);
                            ext_step = (cmd.op == LSX_OP_EXT_READ_INC);
                        end
                        default: begin
                            next_busy = 1'b0;
                            next_state = LSX_ST_IDLE;
                        end
                    endcase
                    if (is_prog) begin
                        next_data_wdata = data_wdata;
                    end
                    if (!is_write && !is_prog
                        && cmd.op != LSX_OP_DIRECT_READ) begin
                        next_busy = 1'b0;
                    end
                end
            end
            LSX_ST_ACCESS: begin
                // Second cycle: data ops finish, program reads wait.
                if (held.op == LSX_OP_DIRECT_READ) begin
                    next_wb = {1'b1, held.dest, data_rdata};
                end
                if (held.op == LSX_OP_PROG_READ
                    || held.op == LSX_OP_PROG_READ_INC
                    || held.op == LSX_OP_EXT_READ
                    || held.op == LSX_OP_EXT_READ_INC) begin
                    next_state = LSX_ST_WAIT;
                end else begin
                    next_busy = 1'b0;
                    next_state = LSX_ST_IDLE;
                end
            end
            LSX_ST_WAIT: begin
                // Third cycle: program byte returns to the register.
                next_wb = {1'b1, held.dest, prog_rdata};
                next_busy = 1'b0;
                next_state = LSX_ST_IDLE;
            end
            default: begin
                next_busy = 1'b0;
                next_state = LSX_ST_IDLE;
            end
        endcase
    end

    // Register all sequencer state and outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= LSX_ST_IDLE;
            held <= '0;
            busy <= 1'b0;
            wb <= '0;
            data_re <= 1'b0;
            data_we <= 1'b0;
            data_addr <= `LSX_PTR_RESET;
            data_wdata <= `LSX_BYTE_RESET;
            prog_re <= 1'b0;
            prog_addr <= 24'h000000;
        end else begin
            state <= next_state;
            held <= next_held;
            busy <= next_busy;
            wb <= next_wb;
            data_re <= next_data_re;
            data_we <= next_data_we;
            data_addr <= next_data_addr;
            data_wdata <= next_data_wdata;
            prog_re <= next_prog_re;
            prog_addr <= next_prog_addr;
        end
    end
endmodule
`default_nettype wire

/* include/lsx_consts.svh */
// Constants of the load and store execution block.
// Contract
// - direct_read: copy data byte, 2 cycles.
// - direct_write: store source byte, 2 cycles.
// - ptr_a post-increment write, store then add.
// - ptr_a pre-decrement write, subtract then store.
// - ptr_b post-increment write, store then add.
// - ptr_b pre-decrement write, subtract then store.
// - ptr_c post-increment write, store then add.
// - ptr_c pre-decrement write, subtract then store.
// - offset_write: ptr_c plus displacement, pointer kept.
// - program_memory_read post-increment ptr_c, 3 cycles.
// - extended_program_read uses page extension, 3 cycles.
`ifndef LSX_CONSTS_SVH
`define LSX_CONSTS_SVH
`define LSX_DATA_CYCLES 2
`define LSX_PROG_CYCLES 3
`define LSX_PTR_RESET 16'h0000
`define LSX_PAGE_RESET 8'h00
`define LSX_BYTE_RESET 8'h00
`endif

/* include/lsx_pkg.sv */
// Types shared by the load and store execution block.
package lsx_pkg;
    typedef enum logic [3:0] {
        LSX_OP_DIRECT_READ = 4'h0,
        LSX_OP_DIRECT_WRITE = 4'h1,
        LSX_OP_WRITE_PLAIN = 4'h2,
        LSX_OP_WRITE_POSTINC = 4'h3,
        LSX_OP_WRITE_PREDEC = 4'h4,
        LSX_OP_OFFSET_WRITE = 4'h5,
        LSX_OP_PROG_READ = 4'h6,
        LSX_OP_PROG_READ_INC = 4'h7,
        LSX_OP_EXT_READ = 4'h8,
        LSX_OP_EXT_READ_INC = 4'h9
    } lsx_op_e;

    typedef enum logic [1:0] {
        LSX_PTR_A = 2'h0,
        LSX_PTR_B = 2'h1,
        LSX_PTR_C = 2'h2
    } lsx_ptr_e;

    typedef struct packed {
        lsx_op_e op;
        lsx_ptr_e ptr;
        logic [4:0] dest;
        logic [7:0] source_register;
        logic [15:0] address;
        logic [5:0] displacement;
    } lsx_cmd_s;

    typedef struct packed {
        logic valid;
        logic [4:0] dest;
        logic [7:0] data;
    } lsx_wb_s;

    typedef enum logic [3:0] {
        LSX_ST_IDLE = 4'b0001,
        LSX_ST_ACCESS = 4'b0010,
        LSX_ST_WAIT = 4'b0100,
        LSX_ST_DONE = 4'b1000
    } lsx_state_e;
endpackage

/* hw/lsx_pointer.sv */
// One 16-bit pointer pair with full-width step logic.
`timescale 1ns/1ps
`default_nettype none
`include "lsx_consts.svh"
module lsx_pointer (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [15:0] load_value,
    input wire logic step_up,
    input wire logic step_down,
    output logic [15:0] value,
    output logic [15:0] value_dec
);
    import lsx_pkg::*;
    logic [15:0] next_value;

    // Decrement borrows from the high byte on wrap.
    assign value_dec = value - 16'h0001;

    // Next pointer value: load, then step, else hold.
    always_comb begin
        next_value = value;
        if (load) begin
            next_value = load_value;
        end else if (step_up) begin
            next_value = value + 16'h0001;
        end else if (step_down) begin
            next_value = value_dec;
        end
    end

    // Register the pointer.
    always_ff @(posedge clk) begin
        if (rst) begin
            value <= `LSX_PTR_RESET;
        end else begin
            value <= next_value;
        end
    end
endmodule
`default_nettype wire

/* hw/lsx_ext_pointer.sv */
// The 8-bit page extension above ptr_c plus its carry step logic.
`timescale 1ns/1ps
`default_nettype none
`include "lsx_consts.svh"
module lsx_ext_pointer (
    input wire logic clk,
    input wire logic rst,
    input wire logic page_load,
    input wire logic [7:0] page_value,
    input wire logic ext_step,
    input wire logic [15:0] ptr_c,
    output logic [7:0] program_page_extension,
    output logic ext_carry
);
    import lsx_pkg::*;
    logic [7:0] next_page;

    // An ext_step increment of the low word carries into the page byte.
    assign ext_carry = (ptr_c == 16'hffff);

    // Next page value.
    always_comb begin
        next_page = program_page_extension;
        if (page_load) begin
            next_page = page_value;
        end else if (ext_step && ext_carry) begin
            next_page = program_page_extension + 8'h01;
        end
    end

    // Register the page byte.
    always_ff @(posedge clk) begin
        if (rst) begin
            program_page_extension <= `LSX_PAGE_RESET;
        end else begin
            program_page_extension <= next_page;
        end
    end
endmodule
`default_nettype wire

/* dv/lsx_chk.sv */
// Port-level assertions for the load and store execution unit.
`timescale 1ns/1ps
`default_nettype none
module lsx_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic busy,
    input wire lsx_pkg::lsx_wb_s wb,
    input wire logic data_re,
    input wire logic data_we,
    input wire logic [15:0] data_addr,
    input wire logic [7:0] data_rdata,
    input wire logic [7:0] prog_rdata,
    input wire logic prog_re,
    input wire logic [23:0] prog_addr,
    input wire logic [15:0] ptr_a,
    input wire logic [15:0] ptr_c,
    input wire logic page_load,
    input wire logic [7:0] program_page_extension
);
    import lsx_pkg::*;
    // ------------------------------------------------------------
    // Timing and pairing properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Every command that starts raises at least one memory strobe.
    start_strobe_a: assert property ($rose(busy) |-> data_re || data_we || prog_re)
        else $error("busy rose without a memory strobe");
    strobe_pulse_a: assert property (data_re || data_we |=> !data_re && !data_we)
        else $error("data strobe held longer than one cycle");
    read_wb_a: assert property (data_re |=> wb.valid && !busy && wb.data == $past(data_rdata))
        else $error("direct read did not write back in two cycles");
    write_time_a: assert property (data_we |-> busy ##1 !busy && !wb.valid)
        else $error("data write did not finish in two cycles");
    prog_time_a: assert property (prog_re |-> busy ##1 busy && !wb.valid ##1 !busy && wb.valid && wb.data == $past(prog_rdata))
        else $error("program read did not finish in three cycles");
    prog_addr_a: assert property (prog_re |-> prog_addr[15:0] == $past(ptr_c))
        else $error("program address is not the pointer before the step");
    post_inc_a: assert property (data_we && ptr_a == $past(ptr_a) + 16'h1 |-> data_addr == $past(ptr_a))
        else $error("post-increment stored at the stepped address");
    pre_dec_a: assert property (data_we && ptr_a == $past(ptr_a) - 16'h1 |-> data_addr == ptr_a)
        else $error("pre-decrement stored at the old address");
    page_carry_a: assert property (prog_re && !$past(page_load) && program_page_extension != $past(program_page_extension) |-> program_page_extension == $past(program_page_extension) + 8'h1 && ptr_c == 16'h0000)
        else $error("page extension changed without a pointer carry");
    // Main scenarios seen at least once.
    cover property (data_re);
    cover property (data_we && ptr_a != $past(ptr_a));
    cover property (prog_re && program_page_extension != $past(program_page_extension));
endmodule
`default_nettype wire

/* dv/lsx_mem_model.sv */
// Behavioural data SRAM and program flash facing the execution unit.
`timescale 1ns/1ps
`default_nettype none
module lsx_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic data_re,
    input wire logic data_we,
    input wire logic [15:0] data_addr,
    input wire logic [7:0] data_wdata,
    input wire logic prog_re,
    input wire logic [23:0] prog_addr,
    output logic [7:0] data_rdata,
    output logic [7:0] prog_rdata
);
    // ------------------------------------------------------------
    // Storage and read timing
    // ------------------------------------------------------------
    logic [7:0] sram [0:65535];
    logic [7:0] noise;
    logic [7:0] prog_q;
    logic prog_vld;
    // Idle read lines show a pattern that moves every cycle.
    always_ff @(posedge clk) begin
        noise <= rst ? 8'h00 : noise + 8'h3b;
        prog_vld <= rst ? 1'b0 : prog_re;
        if (prog_re) begin
            prog_q <= prog_addr[7:0] ^ prog_addr[15:8] ^ prog_addr[23:16] ^ 8'h5a;
        end
        if (data_we) begin
            sram[data_addr] <= data_wdata;
        end
    end
    // The SRAM answers in the strobe cycle, the flash one cycle later.
    assign data_rdata = data_re ? sram[data_addr] : noise;
    assign prog_rdata = prog_vld ? prog_q : noise;
endmodule
`default_nettype wire

/* dv/tb_load_store_execution.sv */
// Self-checking testbench for the load and store execution unit.
`timescale 1ns/1ps
`default_nettype none
module tb_load_store_execution;
    import lsx_pkg::*;
    logic clk, rst, cmd_valid, ptr_load, page_load, busy;
    logic data_re, data_we, prog_re;
    lsx_cmd_s cmd;
    lsx_ptr_e ptr_load_sel;
    lsx_wb_s wb;
    logic [15:0] ptr_load_value, data_addr, ptr_a, ptr_b, ptr_c;
    logic [7:0] page_value, data_rdata, prog_rdata, data_wdata;
    logic [7:0] program_page_extension;
    logic [23:0] prog_addr;
    int n_fail = 0;
    int checked = 0;
    lsx_exec dut (.clk, .rst, .cmd_valid, .cmd, .ptr_load, .ptr_load_sel,
        .ptr_load_value, .page_load, .page_value, .data_rdata, .prog_rdata,
        .busy, .wb, .data_re, .data_we, .data_addr, .data_wdata, .prog_re,
        .prog_addr, .ptr_a, .ptr_b, .ptr_c, .program_page_extension);
    lsx_mem_model mem (.clk, .rst, .data_re, .data_we, .data_addr,
        .data_wdata, .prog_re, .prog_addr, .data_rdata, .prog_rdata);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] exp,
            input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] fbyte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
    endfunction
    function automatic logic [15:0] ptr_of(input lsx_ptr_e p);
        return p == LSX_PTR_A ? ptr_a : p == LSX_PTR_B ? ptr_b : ptr_c;
    endfunction
    // Offers one command and returns in its first execution cycle.
    task automatic go(input lsx_op_e op, input lsx_ptr_e p,
            input logic [7:0] src, input logic [15:0] a, input logic [5:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, p, 5'h11, src, a, d};
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        chk("busy start", 24'h1, busy);
    endtask
    // Moves to the last cycle of a command and checks its end.
    task automatic fin(input int n, input logic rd, input logic [7:0] exp);
        repeat (n - 1) @(negedge clk);
        chk("busy end", 24'h0, busy);
        chk("wb valid", {23'h0, rd}, wb.valid);
        chk("wb data", rd ? {16'h0, exp} : {16'h0, wb.data}, wb.data);
        chk("wb dest", rd ? 24'h11 : {19'h0, wb.dest}, wb.dest);
    endtask
    task automatic set_ptr(input lsx_ptr_e p, input logic [15:0] v);
        @(posedge clk);
        ptr_load <= 1'b1;
        ptr_load_sel <= p;
        ptr_load_value <= v;
        @(posedge clk);
        ptr_load <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_direct;
        go(LSX_OP_DIRECT_WRITE, LSX_PTR_A, 8'ha5, 16'h1234, 6'h00);
        chk("we", 24'h1, data_we);
        chk("w addr", 24'h1234, data_addr);
        chk("w data", 24'ha5, data_wdata);
        fin(2, 1'b0, 8'h00);
        go(LSX_OP_DIRECT_READ, LSX_PTR_A, 8'h00, 16'h1234, 6'h00);
        chk("re", 24'h1, data_re);
        chk("r addr", 24'h1234, data_addr);
        fin(2, 1'b1, 8'ha5);
    endtask
    // Both step forms on every pointer, across the byte boundary.
    task automatic t_pointers;
        lsx_ptr_e p;
        for (int i = 0; i < 3; i++) begin
            p = lsx_ptr_e'(i);
            set_ptr(p, 16'h00ff);
            go(LSX_OP_WRITE_POSTINC, p, 8'h30 + 8'(i), 16'h0, 6'h0);
            chk("inc addr", 24'h00ff, data_addr);
            chk("inc ptr", 24'h0100, ptr_of(p));
            fin(2, 1'b0, 8'h00);
            chk("inc mem", 8'h30 + 8'(i), mem.sram[16'h00ff]);
            go(LSX_OP_WRITE_PREDEC, p, 8'h40 + 8'(i), 16'h0, 6'h0);
            chk("dec addr", 24'h00ff, data_addr);
            chk("dec ptr", 24'h00ff, ptr_of(p));
            fin(2, 1'b0, 8'h00);
            chk("dec mem", 8'h40 + 8'(i), mem.sram[16'h00ff]);
        end
    endtask
    task automatic t_offset;
        set_ptr(LSX_PTR_C, 16'h0ffe);
        go(LSX_OP_OFFSET_WRITE, LSX_PTR_C, 8'h77, 16'h0, 6'h3f);
        chk("ofs addr", 24'h103d, data_addr);
        chk("ofs ptr", 24'h0ffe, ptr_c);
        fin(2, 1'b0, 8'h00);
        chk("ofs mem", 24'h77, mem.sram[16'h103d]);
    endtask
    // Plain and extended program reads from the top of a page.
    task automatic t_prog;
        @(posedge clk);
        page_load <= 1'b1;
        page_value <= 8'h07;
        @(posedge clk);
        page_load <= 1'b0;
        set_ptr(LSX_PTR_C, 16'hffff);
        go(LSX_OP_PROG_READ_INC, LSX_PTR_C, 8'h0, 16'h0, 6'h0);
        chk("p addr", 24'h00ffff, prog_addr);
        chk("p ptr", 24'h0000, ptr_c);
        chk("p page", 24'h07, program_page_extension);
        fin(3, 1'b1, fbyte(24'h00ffff));
        set_ptr(LSX_PTR_C, 16'hffff);
        go(LSX_OP_EXT_READ_INC, LSX_PTR_C, 8'h0, 16'h0, 6'h0);
        chk("x addr", 24'h07ffff, prog_addr);
        chk("x ptr", 24'h0000, ptr_c);
        chk("x page", 24'h08, program_page_extension);
        fin(3, 1'b1, fbyte(24'h07ffff));
    endtask
    task automatic stop_test;
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Clock, reset and the main sequence.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        ptr_load = 1'b0;
        ptr_load_sel = LSX_PTR_A;
        ptr_load_value = 16'h0000;
        page_load = 1'b0;
        page_value = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_direct();
        t_pointers();
        t_offset();
        t_prog();
        stop_test();
    end
    // Watchdog at 2500 clock cycles, well beyond the fewer than a hundred cycles the scenarios need.
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
endmodule
bind lsx_exec lsx_chk chk (.clk, .rst, .busy, .wb, .data_re, .data_we,
    .data_addr, .data_rdata, .prog_rdata, .prog_re, .prog_addr, .ptr_a,
    .ptr_c, .page_load, .program_page_extension);
`default_nettype wire
